// File: pkg/pwm_cycle_pkg.sv
// shared constants and types for the pwm cycle configuration block
package pwm_cycle_pkg;
  localparam logic [7:0] CFG_ADDR = 8'h00_D9;
  localparam int NUM_MODULES = 6;
  localparam int BIT_RELOAD_SEL = 7;
  localparam int BIT_OVF_IE = 6;
  localparam int BIT_OVF_FLAG = 5;
  localparam int BIT_CLSEL_LO = 0;
  localparam logic [7:0] CFG_RESET = 8'h00_00;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h00_E3;
  localparam logic [1:0] CLSEL_8 = 2'h0;
  localparam logic [1:0] CLSEL_9 = 2'h1;
  localparam logic [1:0] CLSEL_10 = 2'h2;
  localparam logic [1:0] CLSEL_11 = 2'h3;

  typedef struct packed {
    logic        pwm_en;
    logic        wide_pwm_enable;
  } module_mode_s;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [7:0]  wdata;
  } sfr_req_s;
endpackage

// File: src/pwm_ovf_detect.sv
// picks the counter bit that marks one pwm cycle and reports its overflow
module pwm_ovf_detect
  import pwm_cycle_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // counter
  input wire logic [15:0] count,
  input wire logic count_tick,
  input wire logic [1:0] cycle_length_select,
  // event
  output logic ovf_pulse
);
  logic [10:0] low_mask;
  logic wrap;

  // cycle length 8..11 bits from the select code
  assign low_mask = (cycle_length_select == CLSEL_8)  ? 11'h0_0FF :
                    (cycle_length_select == CLSEL_9)  ? 11'h0_1FF :
                    (cycle_length_select == CLSEL_10) ? 11'h0_3FF :
                                                        11'h7_FF; // [RULE8] [RULE10]
  // overflow of the chosen bit: low bits all ones as the counter steps
  assign wrap = count_tick && ((count[10:0] & low_mask) == low_mask); // [RULE5]

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovf_pulse <= 1'b0;
    end else begin
      ovf_pulse <= wrap;
    end
  end
endmodule

// File: src/pwm_cycle_config.sv
// pwm cycle configuration register, overflow flag and auto-reload steering
// Operation
// RULE1: select bit routes compare accesses to reload storage
// RULE2: reload value loads compare in 9-11 bit pwm
// RULE3: reload storage has no effect otherwise
// RULE4: interrupt request while flag and enable set
// RULE5: flag set on overflow of selected bit
// RULE6: hardware or software sets flag, software clears
// RULE7: bits four to two read zero, ignore writes
// RULE8: codes 00/01/10 give 8/9/10 bit cycle
// RULE9: cycle length applies to non-16-bit pwm channels
// RULE10: code 11 gives 11 bit cycle
// RULE11: per-module wide enable picks 16-bit pwm
module pwm_cycle_config
  import pwm_cycle_pkg::*;
#(
  parameter int MODULES = NUM_MODULES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // special function register bus
  input wire sfr_req_s sfr_req,
  input wire logic compare_select,
  input wire logic [$clog2(MODULES)-1:0] compare_index,
  input wire logic compare_high,
  output logic [7:0] rdata,
  output logic cfg_hit,
  // counter array side
  input wire logic [15:0] count,
  input wire logic count_tick,
  input wire module_mode_s [MODULES-1:0] module_mode,
  // outputs
  output logic [1:0] cycle_length_select,
  output logic [MODULES-1:0] uses_shared_length,
  output logic [MODULES-1:0] reload_strobe,
  output logic [MODULES-1:0][15:0] module_compare_register,
  output logic irq_request
);
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [MODULES-1:0][15:0] reload_reg;
  logic [MODULES-1:0][15:0] compare_reg;
  logic ovf_pulse;
  logic cfg_wr;
  logic cmp_wr;
  logic reload_sel;
  logic [7:0] rd_mux;
  logic [MODULES-1:0] pwm_short;

  assign reload_sel = cfg_reg[BIT_RELOAD_SEL];
  assign cfg_wr = sfr_req.wr && sfr_req.addr == CFG_ADDR;
  assign cmp_wr = sfr_req.wr && compare_select;

  pwm_ovf_detect u_ovf (
    .clk_sys(clk_sys),
    .srst(srst),
    .count(count),
    .count_tick(count_tick),
    .cycle_length_select(cfg_reg[BIT_CLSEL_LO +: 2]),
    .ovf_pulse(ovf_pulse)
  );

  // flag: set wins over a software clear in the same cycle
  assign cfg_next = cfg_wr ?
    ((sfr_req.wdata & CFG_WRITE_MASK) | ({7'h00, ovf_pulse} << BIT_OVF_FLAG)) : // [RULE7] [RULE6]
    (cfg_reg | ({7'h00, ovf_pulse} << BIT_OVF_FLAG)); // [RULE5] [RULE6]

  // channels in short pwm follow the shared cycle length
  generate
    for (genvar m = 0; m < MODULES; m++) begin : g_mode
      assign pwm_short[m] = module_mode[m].pwm_en && !module_mode[m].wide_pwm_enable; // [RULE11] [RULE9]
    end
  endgenerate

  // read path: compare or reload storage at the same address
  assign rd_mux = (sfr_req.addr == CFG_ADDR) ? cfg_reg :
    compare_select ? (reload_sel ?
      (compare_high ? reload_reg[compare_index][15:8] : reload_reg[compare_index][7:0]) :
      (compare_high ? compare_reg[compare_index][15:8] : compare_reg[compare_index][7:0])) :
    8'h00; // [RULE1]

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfg_reg <= CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata <= 8'h00;
      cfg_hit <= 1'b0;
      irq_request <= 1'b0;
      cycle_length_select <= CLSEL_8;
      uses_shared_length <= '0;
    end else begin
      rdata <= sfr_req.rd ? rd_mux : 8'h00;
      cfg_hit <= sfr_req.addr == CFG_ADDR && (sfr_req.rd || sfr_req.wr);
      irq_request <= cfg_next[BIT_OVF_FLAG] && cfg_next[BIT_OVF_IE]; // [RULE4]
      cycle_length_select <= cfg_next[BIT_CLSEL_LO +: 2]; // [RULE8] [RULE9]
      uses_shared_length <= pwm_short; // [RULE9]
    end
  end

  // compare/reload storage and reload on cycle overflow
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reload_reg <= '0;
      compare_reg <= '0;
      reload_strobe <= '0;
    end else begin
      for (int m = 0; m < MODULES; m++) begin
        reload_strobe[m] <= 1'b0;
        if (ovf_pulse && pwm_short[m] && cfg_reg[BIT_CLSEL_LO +: 2] != CLSEL_8) begin
          compare_reg[m] <= reload_reg[m]; // [RULE2] [RULE3]
          reload_strobe[m] <= 1'b1;
        end
      end
      if (cmp_wr && reload_sel) begin // [RULE1]
        if (compare_high) reload_reg[compare_index][15:8] <= sfr_req.wdata;
        else reload_reg[compare_index][7:0] <= sfr_req.wdata;
      end else if (cmp_wr) begin // [RULE1]
        if (compare_high) compare_reg[compare_index][15:8] <= sfr_req.wdata;
        else compare_reg[compare_index][7:0] <= sfr_req.wdata;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      module_compare_register <= '0;
    end else begin
      module_compare_register <= compare_reg;
    end
  end

  // assertions
  AST_IRQ_FOLLOWS: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
    irq_request == (cfg_reg[BIT_OVF_FLAG] && cfg_reg[BIT_OVF_IE]))
    else $error("irq request does not follow flag and enable");
  AST_OVF_SETS: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
    ovf_pulse |=> cfg_reg[BIT_OVF_FLAG])
    else $error("overflow did not set flag");
  AST_NO_AUTOCLEAR: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
    cfg_reg[BIT_OVF_FLAG] && !cfg_wr |=> cfg_reg[BIT_OVF_FLAG])
    else $error("flag cleared without software write");
  AST_SW_SET: assert property (@(posedge clk_sys) disable iff (srst) // [RULE6]
    cfg_wr && sfr_req.wdata[BIT_OVF_FLAG] |=> cfg_reg[BIT_OVF_FLAG])
    else $error("software write of one did not set flag");
  AST_UNUSED_ZERO: assert property (@(posedge clk_sys) disable iff (srst) // [RULE7]
    cfg_reg[4:2] == 3'h0)
    else $error("unused bits not zero");
  AST_CLSEL_TRACK: assert property (@(posedge clk_sys) disable iff (srst) // [RULE8]
    cfg_wr |=> cycle_length_select == $past(sfr_req.wdata[1:0]))
    else $error("cycle length select did not take write");
  AST_RELOAD_ONLY_SHORT: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
    reload_strobe[0] |-> $past(pwm_short[0]))
    else $error("reload outside short pwm");
  AST_RELOAD_VALUE: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
    reload_strobe[0] && !$past(cmp_wr) |-> compare_reg[0] == $past(reload_reg[0]))
    else $error("compare not loaded from reload");
  AST_WIDE_IGNORES: assert property (@(posedge clk_sys) disable iff (srst) // [RULE11] [RULE9]
    module_mode[0].wide_pwm_enable |=> !uses_shared_length[0])
    else $error("wide channel follows shared length");

  // named steps for the multi-cycle checks
  sequence s_enabled_wrap;
    ovf_pulse && cfg_next[BIT_OVF_IE];
  endsequence
  sequence s_short_wrap;
    ovf_pulse && pwm_short[0] && cfg_reg[BIT_CLSEL_LO +: 2] != CLSEL_8;
  endsequence
  sequence s_plain_wrap;
    ovf_pulse && cfg_reg[BIT_CLSEL_LO +: 2] == CLSEL_8;
  endsequence
  sequence s_low_compare_write;
    cmp_wr && !reload_sel && compare_index == '0 && !compare_high;
  endsequence
  sequence s_high_reload_write;
    cmp_wr && reload_sel && compare_index == '0 && compare_high;
  endsequence

  AST_IRQ_MASKED: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4]
    !cfg_reg[BIT_OVF_IE] |-> !irq_request)
    else $error("irq request while enable is clear");
  AST_OVF_TO_IRQ: assert property (@(posedge clk_sys) disable iff (srst) // [RULE4] [RULE5]
    s_enabled_wrap |=> irq_request)
    else $error("enabled overflow did not raise irq request");
  AST_RELOAD_STROBE: assert property (@(posedge clk_sys) disable iff (srst) // [RULE2]
    s_short_wrap |=> reload_strobe[0])
    else $error("short pwm overflow did not reload");
  AST_NO_RELOAD_PLAIN: assert property (@(posedge clk_sys) disable iff (srst) // [RULE3]
    s_plain_wrap |=> !reload_strobe[0])
    else $error("reload in eight bit cycle");
  AST_COMPARE_WRITE: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
    s_low_compare_write |=> ##1 module_compare_register[0][7:0] == $past(sfr_req.wdata, 2))
    else $error("compare write did not reach compare storage");
  AST_RELOAD_WRITE: assert property (@(posedge clk_sys) disable iff (srst) // [RULE1]
    s_high_reload_write |=> reload_reg[0][15:8] == $past(sfr_req.wdata))
    else $error("reload write did not reach reload storage");
  AST_WRITE_MASK: assert property (@(posedge clk_sys) disable iff (srst) // [RULE7] [RULE6]
    cfg_wr && !ovf_pulse |=> cfg_reg == ($past(sfr_req.wdata) & CFG_WRITE_MASK))
    else $error("configuration write not taken as masked");
  AST_SHORT_FOLLOWS: assert property (@(posedge clk_sys) disable iff (srst) // [RULE9]
    module_mode[0].pwm_en && !module_mode[0].wide_pwm_enable |=> uses_shared_length[0])
    else $error("short pwm channel ignores shared length");
  AST_WRAP_NEEDS_LOW: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5]
    !(count_tick && count[7:0] == 8'hFF) |=> !ovf_pulse)
    else $error("overflow without counter wrap");
  AST_WRAP_EIGHT: assert property (@(posedge clk_sys) disable iff (srst) // [RULE5] [RULE8]
    count_tick && cfg_reg[BIT_CLSEL_LO +: 2] == CLSEL_8 && count[7:0] == 8'hFF |=> ovf_pulse)
    else $error("eight bit wrap missed");
  AST_WRAP_LONGEST: assert property (@(posedge clk_sys) disable iff (srst) // [RULE10]
    count_tick && cfg_reg[BIT_CLSEL_LO +: 2] == CLSEL_11 && count[10:0] == 11'h7_FF
    |=> ovf_pulse)
    else $error("eleven bit wrap missed");

  // bus side
  AST_CFG_HIT: assert property (@(posedge clk_sys) disable iff (srst)
    (sfr_req.rd || sfr_req.wr) && sfr_req.addr == CFG_ADDR |=> cfg_hit)
    else $error("configuration access not reported");
  AST_RDATA_IDLE: assert property (@(posedge clk_sys) disable iff (srst)
    !sfr_req.rd |=> rdata == 8'h00)
    else $error("read data not zero without read");
endmodule

// File: dv/pwm_cycle_config_bench.sv
// self-checking bench for the pwm cycle configuration block
module pwm_cycle_config_bench;
  import pwm_cycle_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0;
  logic srst = 1;
  sfr_req_s sfr_req = '0;
  logic compare_select = 0;
  logic [2:0] compare_index = '0;
  logic compare_high = 0;
  logic [15:0] count = '0;
  logic count_tick = 0;
  module_mode_s [5:0] module_mode = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  logic [5:0] e;
  logic cfg_hit;
  logic irq_request;
  logic rd_d = 0;
  logic hit_d = 0;
  logic [1:0] cycle_length_select;
  logic [5:0] uses_shared_length;
  logic [5:0] reload_strobe;
  logic [5:0][15:0] module_compare_register;
  logic [7:0] expq[$];
  int fails = 0;
  int checks_done = 0;

  pwm_cycle_config i_pwm_cycle_config (.clk_sys(clk_sys), .srst(srst), .sfr_req(sfr_req),
    .compare_select(compare_select), .compare_index(compare_index),
    .compare_high(compare_high), .rdata(rdata), .cfg_hit(cfg_hit), .count(count),
    .count_tick(count_tick), .module_mode(module_mode),
    .cycle_length_select(cycle_length_select), .uses_shared_length(uses_shared_length),
    .reload_strobe(reload_strobe), .module_compare_register(module_compare_register),
    .irq_request(irq_request));

  initial forever #2 clk_sys = ~clk_sys;

  // read data compare
  task automatic chk_rdata(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // single flag compare
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // multi-bit output compare
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus access; a read notes its expected data
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic cs,
                     input logic hi, input logic [7:0] x);
    @(negedge clk_sys);
    sfr_req = '{w, ~w, a, d};
    compare_select = cs;
    compare_high = hi;
    if (!w) expq.push_back(x);
    @(negedge clk_sys);
    sfr_req = '0;
    compare_select = 0;
  endtask

  task automatic ovf(input logic [15:0] c, input logic [5:0] s);
    @(negedge clk_sys);
    count = c;
    count_tick = 1;
    @(negedge clk_sys);
    count_tick = 0;
    @(negedge clk_sys);
    chk_word(16'(reload_strobe), 16'(s));
    repeat (3) @(negedge clk_sys);
  endtask

  // read data shows the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d) begin
      if (expq.size() == 0) begin
        fails++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, rdata, 8'h00);
      end else chk_rdata(rdata, expq.pop_front());
    end
    if (hit_d || cfg_hit) chk_bit(cfg_hit, hit_d);
    rd_d <= sfr_req.rd;
    hit_d <= (sfr_req.rd || sfr_req.wr) && sfr_req.addr == CFG_ADDR;
  end

  task automatic stop_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    v = 8'($urandom(92));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 0;
    acc(0, CFG_ADDR, 8'h00, 0, 0, CFG_RESET);
    v = 8'($urandom());
    acc(1, CFG_ADDR, v, 0, 0, 8'h00);
    acc(0, CFG_ADDR, 8'h00, 0, 0, v & CFG_WRITE_MASK);
    chk_bit(irq_request, v[6] & v[5]);
    chk_word(16'(cycle_length_select), 16'(v[1:0]));
    $display("test registers done");
    module_mode = 12'($urandom());
    module_mode[0] = 2'b10;
    for (int m = 0; m < 6; m++) e[m] = module_mode[m].pwm_en & ~module_mode[m].wide_pwm_enable;
    repeat (2) @(negedge clk_sys);
    chk_word(16'(uses_shared_length), 16'(e));
    $display("test modes done");
    acc(1, CFG_ADDR, 8'h80, 0, 0, 8'h00);
    acc(1, 8'hFB, 8'h5A, 1, 0, 8'h00);
    acc(1, 8'hFC, 8'h01, 1, 1, 8'h00);
    acc(0, 8'hFB, 8'h00, 1, 0, 8'h5A);
    for (int c = 0; c < 4; c++) begin
      acc(1, CFG_ADDR, 8'(8'h40 | c), 0, 0, 8'h00);
      @(negedge clk_sys);
      chk_bit(irq_request, 1'b0);
      ovf(16'((1 << (8 + c)) - 1), (c == 0) ? 6'h00 : e);
      chk_bit(irq_request, 1'b1);
      chk_word(module_compare_register[0], (c == 0) ? 16'h0000 : 16'h015A);
      acc(0, CFG_ADDR, 8'h00, 0, 0, 8'(8'h60 | c));
      if (c == 0) acc(0, 8'hFB, 8'h00, 1, 0, 8'h00);
    end
    $display("test overflow and reload done");
    for (int i = 0; i < 20 && expq.size() > 0; i++) @(posedge clk_sys);
    if (expq.size() > 0) fails++;
    stop_test();
  end
endmodule
